// *** rtl/gmb_top.sv ***
// gmb_top: mode control, serial register port and rate filtering of a dual-axis rate sensor.
// assumes raw rate samples from a converter on clk_i and a mode-3 serial master on the pins.
//
// How it works
// RL1: writing bit 1 of register 0x10 moves the device into measurement.
// RL2: clearing that bit returns the device to low-power standby.
// RL3: after reset the device sits in standby awaiting a command.
// RL4: in standby a serial command reaches one register only; no bursts.
// RL5: standby freezes the rate output registers.
// RL6: measurement start settles offsets within the start-up time.
// RL7: filter resets to all-pass high-pass and 480 Hz low-pass.
// RL8: low-pass code bits 2:0 pick a pole from 480 down to 20 Hz.
// RL9: high-pass code bits 7:4 pick all-pass, doubling poles, or 11.30 Hz.
// RL10: high-pass stage tracks the offset and subtracts it.
// RL11: changing the high-pass code keeps the offset estimate.
// RL12: leaving measurement drops the held offset estimate.
// RL13: evaluation mode emits each axis as a 144 kHz density stream.
// RL14: evaluation mode bypasses the band-pass filter.
// RL15: evaluation mode stays active and ignores standby requests.
// RL16: registers stay reachable in evaluation mode; streams need no traffic.
// RL17: widest low-pass setting keeps group delay under half a millisecond.
// RL18: both pole selections are writable through the serial port.
// RL19: host must not write reserved high-pass codes 1011 to 1111.
// RL20: new filter codes act at once without a mode change.
`timescale 1ns/10ps
`default_nettype none
module gmb_top #(
  parameter int unsigned START_CYCLES = gmb_pkg::START_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               spi_cs_n_i,
  input  wire logic               spi_sclk_i,
  input  wire logic               spi_mosi_i,
  output logic                    spi_miso_o,
  output logic                    spi_miso_oe_o,
  input  wire logic               analog_sel_i,
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] rate_x_i,
  input  wire logic signed [15:0] rate_y_i,
  output logic                    x_axis_density_out_o,
  output logic                    y_axis_density_out_o,
  output logic                    pump_output_o,
  output logic                    measuring_o
);

  // ---------------------------------------------------------------
  // pin synchronisers: two flops each before anything looks at them
  logic [1:0] cs_n_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] mosi_sync_q;
  logic [1:0] asel_sync_q;
  logic       sclk_prev_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_n_sync_q <= 2'h3;
      sclk_sync_q <= 2'h3;
      mosi_sync_q <= 2'h0;
      asel_sync_q <= 2'h0;
      sclk_prev_q <= 1'b1;
    end else begin
      cs_n_sync_q <= {cs_n_sync_q[0], spi_cs_n_i};
      sclk_sync_q <= {sclk_sync_q[0], spi_sclk_i};
      mosi_sync_q <= {mosi_sync_q[0], spi_mosi_i};
      asel_sync_q <= {asel_sync_q[0], analog_sel_i};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic analog_mode;

  assign cs_act      = ~cs_n_sync_q[1];
  assign sclk_rise   = cs_act & sclk_sync_q[1] & ~sclk_prev_q;
  assign sclk_fall   = cs_act & ~sclk_sync_q[1] & sclk_prev_q;
  assign analog_mode = asel_sync_q[1];

  // ---------------------------------------------------------------
  // register state
  logic [7:0]          power_q;
  logic [7:0]          filter_q;
  logic signed [15:0]  data_x_q;
  logic signed [15:0]  data_y_q;
  gmb_pkg::gmb_state_t state_q;
  gmb_pkg::gmb_state_t state_d;

  function automatic logic [7:0] read_reg(input logic [6:0] addr);
    case (addr)
      gmb_pkg::ADDR_RATE_X_LO:  read_reg = data_x_q[7:0];
      gmb_pkg::ADDR_RATE_X_HI:  read_reg = data_x_q[15:8];
      gmb_pkg::ADDR_RATE_Y_LO:  read_reg = data_y_q[7:0];
      gmb_pkg::ADDR_RATE_Y_HI:  read_reg = data_y_q[15:8];
      gmb_pkg::ADDR_POWER_CTRL: read_reg = power_q;
      gmb_pkg::ADDR_FILTER:     read_reg = filter_q;
      default:                  read_reg = 8'h00;  // unmapped reads as zero
    endcase
  endfunction

  // ---------------------------------------------------------------
  // serial slave, clock idle high: sample on rising, shift out on falling
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_in_q;
  logic [7:0] tx_q;
  logic       hdr_done_q;
  logic       rw_q;
  logic [6:0] addr_q;
  logic       burst_lock_q;   // set once a standby command has used its one register
  logic       miso_q;
  logic       wr_en_q;
  logic [6:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rx_byte;
  logic       standby;

  assign rx_byte = {shift_in_q[6:0], mosi_sync_q[1]};
  assign standby = (state_q == gmb_pkg::GMB_ST_STANDBY);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_q    <= 3'h0;
      shift_in_q   <= 8'h00;
      tx_q         <= 8'h00;
      hdr_done_q   <= 1'b0;
      rw_q         <= 1'b0;
      addr_q       <= 7'h00;
      burst_lock_q <= 1'b0;
      miso_q       <= 1'b0;
      wr_en_q      <= 1'b0;
      wr_addr_q    <= 7'h00;
      wr_data_q    <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (!cs_act) begin
        // frame over: the next frame starts with a fresh command byte
        bit_cnt_q    <= 3'h0;
        hdr_done_q   <= 1'b0;
        burst_lock_q <= 1'b0;
        tx_q         <= 8'h00;
      end else if (sclk_rise) begin
        shift_in_q <= rx_byte;
        bit_cnt_q  <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          if (!hdr_done_q) begin
            hdr_done_q <= 1'b1;
            rw_q       <= rx_byte[gmb_pkg::SPI_RW_BIT];
            addr_q     <= rx_byte[6:0];
            tx_q       <= rx_byte[gmb_pkg::SPI_RW_BIT] ? read_reg(rx_byte[6:0]) : 8'h00;
          end else if (!burst_lock_q) begin
            wr_en_q   <= ~rw_q; // RL18
            wr_addr_q <= addr_q;
            wr_data_q <= rx_byte;
            // standby allows one register per command; further bytes are ignored
            if (standby) begin
              burst_lock_q <= 1'b1; // RL4
              tx_q         <= 8'h00;
            end else begin
              addr_q <= addr_q + 7'h01;
              tx_q   <= rw_q ? read_reg(addr_q + 7'h01) : 8'h00; // RL16
            end
          end else begin
            tx_q <= 8'h00;
          end
        end
      end else if (sclk_fall) begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign spi_miso_o    = miso_q;
  assign spi_miso_oe_o = cs_act;

  // ---------------------------------------------------------------
  // software registers; reserved bits stay zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_q  <= gmb_pkg::POWER_RESET;
      filter_q <= gmb_pkg::FILTER_RESET; // RL7
    end else if (wr_en_q) begin
      if (wr_addr_q == gmb_pkg::ADDR_POWER_CTRL)
        power_q <= wr_data_q & gmb_pkg::PWR_WRITE_MASK; // RL1 RL2
      if (wr_addr_q == gmb_pkg::ADDR_FILTER)
        filter_q <= wr_data_q & gmb_pkg::FLT_WRITE_MASK; // RL20
    end
  end

  // ---------------------------------------------------------------
  // mode state machine
  logic        meas_req;
  logic [19:0] settle_cnt_q;
  logic        settle_done;

  assign meas_req    = power_q[gmb_pkg::PWR_MEAS_BIT];
  assign settle_done = (32'(settle_cnt_q) >= START_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      gmb_pkg::GMB_ST_STANDBY: begin
        if (meas_req || analog_mode)
          state_d = gmb_pkg::GMB_ST_SETTLE; // RL1
      end
      gmb_pkg::GMB_ST_SETTLE: begin
        if (!meas_req && !analog_mode)
          state_d = gmb_pkg::GMB_ST_STANDBY;
        else if (settle_done)
          state_d = gmb_pkg::GMB_ST_MEASURE; // RL6
      end
      gmb_pkg::GMB_ST_MEASURE: begin
        // evaluation mode holds the device awake whatever the enable bit says
        if (!meas_req && !analog_mode)
          state_d = gmb_pkg::GMB_ST_STANDBY; // RL2 RL15
      end
      default: state_d = gmb_pkg::GMB_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      state_q <= gmb_pkg::GMB_ST_STANDBY; // RL3
    else
      state_q <= state_d;
  end

  // start-up timer; counts only while settling
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      settle_cnt_q <= 20'h00000;
    else if (state_q != gmb_pkg::GMB_ST_SETTLE)
      settle_cnt_q <= 20'h00000;
    else if (!settle_done)
      settle_cnt_q <= settle_cnt_q + 20'h00001;
  end

  assign measuring_o   = (state_q == gmb_pkg::GMB_ST_MEASURE);
  assign pump_output_o = ~standby;

  // ---------------------------------------------------------------
  // filter channels
  gmb_cfg_if cfg_bus ();
  logic               out_valid_x;
  logic               out_valid_y;
  logic signed [15:0] out_x;
  logic signed [15:0] out_y;
  logic               chan_valid;

  assign cfg_bus.lpf_code = filter_q[gmb_pkg::FLT_LPF_LSB +: 3];
  assign cfg_bus.hpf_code = filter_q[gmb_pkg::FLT_HPF_LSB +: 4];
  assign cfg_bus.bypass   = analog_mode; // RL14
  assign cfg_bus.fast     = (state_q == gmb_pkg::GMB_ST_SETTLE); // RL6
  // estimate is wiped when measurement ends and held clear through standby
  assign cfg_bus.clear    = standby; // RL12
  assign chan_valid       = sample_valid_i & ~standby;

  gmb_axis_chan u_chan_x (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .cfg         (cfg_bus.chan),
    .in_valid_i  (chan_valid),
    .in_i        (rate_x_i),
    .out_valid_o (out_valid_x),
    .out_o       (out_x)
  );

  gmb_axis_chan u_chan_y (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .cfg         (cfg_bus.chan),
    .in_valid_i  (chan_valid),
    .in_i        (rate_y_i),
    .out_valid_o (out_valid_y),
    .out_o       (out_y)
  );

  // rate registers only move while awake
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_x_q <= 16'sh0000;
      data_y_q <= 16'sh0000;
    end else if (!standby) begin
      if (out_valid_x)
        data_x_q <= out_x; // RL5
      if (out_valid_y)
        data_y_q <= out_y;
    end
  end

  // ---------------------------------------------------------------
  // evaluation-mode density streams, first-order modulators at a 144 kHz tick
  logic [6:0] tick_cnt_q;
  logic       tick;

  assign tick = (tick_cnt_q == 7'(gmb_pkg::DENSITY_DIV - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      tick_cnt_q <= 7'h00;
    else if (!analog_mode || tick)
      tick_cnt_q <= 7'h00;
    else
      tick_cnt_q <= tick_cnt_q + 7'h01; // RL13
  end

  logic [1:0] density_bit;
  logic signed [15:0] ax_rate [2];

  assign ax_rate[0] = data_x_q;
  assign ax_rate[1] = data_y_q;

  for (genvar a = 0; a < 2; a++) begin : g_density
    logic [15:0] acc_q;
    logic [16:0] sum;
    logic        bit_q;

    // offset-binary input: mid-scale gives a 50 percent density
    assign sum = {1'b0, acc_q} + {1'b0, ax_rate[a] ^ 16'h8000};

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        acc_q <= 16'h0000;
        bit_q <= 1'b0;
      end else if (!analog_mode) begin
        acc_q <= 16'h0000;
        bit_q <= 1'b0;
      end else if (tick) begin
        acc_q <= sum[15:0];
        bit_q <= sum[16]; // RL13
      end
    end

    assign density_bit[a] = bit_q;
  end

  assign x_axis_density_out_o = density_bit[0];
  assign y_axis_density_out_o = density_bit[1];

endmodule
`default_nettype wire

// *** inc/gmb_pkg.sv ***
// gmb_pkg: constants shared by the rate sensor mode and band-pass filter logic.
// assumes a 10 MHz system clock; every figure below is the one the block is built around.
package gmb_pkg;

  // clock and timing figures in their own units
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned START_TIME_MS  = 100;        // standby to settled measurement
  localparam int unsigned START_CYCLES   = START_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DENSITY_HZ     = 144_000;    // evaluation-mode bit stream rate
  localparam int unsigned DENSITY_DIV    = CLK_HZ / DENSITY_HZ;  // rounds down
  localparam int unsigned GROUP_DELAY_US = 500;        // bound on widest low-pass setting

  // register map
  localparam logic [6:0] ADDR_RATE_X_LO    = 7'h08;
  localparam logic [6:0] ADDR_RATE_X_HI    = 7'h09;
  localparam logic [6:0] ADDR_RATE_Y_LO    = 7'h0A;
  localparam logic [6:0] ADDR_RATE_Y_HI    = 7'h0B;
  localparam logic [6:0] ADDR_POWER_CTRL   = 7'h10;
  localparam logic [6:0] ADDR_FILTER       = 7'h11;

  // power_control fields
  localparam int unsigned PWR_MEAS_BIT     = 1;
  localparam int unsigned PWR_TEMP_BIT     = 0;
  localparam logic [7:0]  PWR_WRITE_MASK   = 8'h03;
  localparam logic [7:0]  POWER_RESET      = 8'h00;

  // filter register fields
  localparam int unsigned FLT_HPF_LSB      = 4;
  localparam int unsigned FLT_LPF_LSB      = 0;
  localparam logic [7:0]  FLT_WRITE_MASK   = 8'hF7;
  localparam logic [7:0]  FILTER_RESET     = 8'h00;  // all-pass high, 480 Hz low

  // high-pass codes of note
  localparam logic [3:0]  HPF_ALL_PASS     = 4'h0;
  localparam logic [3:0]  HPF_TOP_CODE     = 4'hA;

  // serial frame
  localparam int unsigned SPI_RW_BIT       = 7;

  // filter arithmetic
  localparam int unsigned RATE_W           = 16;
  localparam int unsigned FRAC_W           = 16;
  localparam int unsigned ACC_W            = RATE_W + FRAC_W;
  localparam int unsigned HPF_SLOW_SHIFT   = 16;   // code 0001, 0.011 Hz
  localparam int unsigned HPF_TOP_SHIFT    = 6;    // code 1010, 11.30 Hz
  localparam int unsigned HPF_FAST_SHIFT   = 4;    // used while settling after start

  typedef enum logic [1:0] {
    GMB_ST_STANDBY,
    GMB_ST_SETTLE,
    GMB_ST_MEASURE
  } gmb_state_t;

endpackage

// *** inc/gmb_cfg_if.sv ***
// gmb_cfg_if: filter configuration carried from the control logic to each axis channel.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface gmb_cfg_if;
  logic [2:0] lpf_code;
  logic [3:0] hpf_code;
  logic       bypass;    // evaluation mode: raw rate straight through
  logic       fast;      // start-up settling: quick offset tracking
  logic       clear;     // drop the held offset estimate

  modport ctrl (output lpf_code, output hpf_code, output bypass, output fast, output clear);
  modport chan (input lpf_code, input hpf_code, input bypass, input fast, input clear);
endinterface
`default_nettype wire

// *** rtl/gmb_axis_chan.sv ***
// gmb_axis_chan: one axis of the single-pole band-pass rate filter.
// assumes samples arrive as one-cycle strobes on the system clock.
`timescale 1ns/10ps
`default_nettype none
module gmb_axis_chan (
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  gmb_cfg_if.chan                          cfg,
  input  wire logic                        in_valid_i,
  input  wire logic signed [15:0]          in_i,
  output logic                             out_valid_o,
  output logic signed [15:0]               out_o
);

  // low-pass pole: each code step roughly halves the corner, code 0 passes straight
  function automatic int unsigned lpf_shift(input logic [2:0] code);
    lpf_shift = int'(code);
  endfunction

  // high-pass pole: doubling codes step the shift by one; reserved codes act as the top code
  function automatic int unsigned hpf_shift(input logic [3:0] code);
    if (code >= gmb_pkg::HPF_TOP_CODE)
      hpf_shift = gmb_pkg::HPF_TOP_SHIFT;
    else
      hpf_shift = gmb_pkg::HPF_SLOW_SHIFT + 1 - int'(code);
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07FFF)
      sat16 = 16'sh7FFF;
    else if (v < -18'sh08000)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction

  logic signed [31:0] est_q;   // offset estimate, 16.16 fixed point
  logic signed [31:0] lp_q;    // low-pass state, 16.16 fixed point
  logic signed [31:0] in_fx;
  logic signed [31:0] hp_fx;
  logic signed [15:0] hp_val;
  logic signed [31:0] lp_next;
  logic               hpf_on;

  assign in_fx  = {in_i, 16'h0000};
  assign hpf_on = (cfg.hpf_code != gmb_pkg::HPF_ALL_PASS) || cfg.fast;
  // subtract the running offset estimate; all-pass leaves it parked, not discarded
  assign hp_val = hpf_on ? sat16(18'(in_i) - 18'($signed(est_q[31:16]))) : in_i; // RL10
  assign hp_fx  = {hp_val, 16'h0000};
  assign lp_next = lp_q + ((hp_fx - lp_q) >>> lpf_shift(cfg.lpf_code)); // RL8

  // offset tracker; a code change only alters the step, so the estimate carries over
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      est_q <= 32'sh0000_0000;
    end else if (cfg.clear) begin
      est_q <= 32'sh0000_0000; // RL12
    end else if (in_valid_i && hpf_on && !cfg.bypass) begin
      if (cfg.fast)
        est_q <= est_q + ((in_fx - est_q) >>> gmb_pkg::HPF_FAST_SHIFT);
      else
        est_q <= est_q + ((in_fx - est_q) >>> hpf_shift(cfg.hpf_code)); // RL9 RL11 RL20
    end
  end

  // low-pass stage; code 0 gives one clock of latency, keeping delay well inside the bound
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp_q <= 32'sh0000_0000;
    end else if (cfg.clear) begin
      lp_q <= 32'sh0000_0000;
    end else if (in_valid_i) begin
      lp_q <= cfg.bypass ? in_fx : lp_next; // RL17
    end
  end

  // registered result
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_o       <= 16'sh0000;
    end else begin
      out_valid_o <= in_valid_i;
      if (in_valid_i)
        out_o <= cfg.bypass ? in_i : lp_next[31:16]; // RL14
    end
  end

endmodule
`default_nettype wire

// *** sim/gmb_top_monitor.sv ***
// gmb_top_monitor: port-level checks of mode control, density streams and the serial enable.
// assumes it is bound into gmb_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module gmb_top_monitor #(
  parameter int unsigned START_CYCLES = 50
) (
  input wire logic               clk_i,
  input wire logic               arst_n_i,
  input wire logic               spi_cs_n_i,
  input wire logic               spi_sclk_i,
  input wire logic               spi_mosi_i,
  input wire logic               spi_miso_o,
  input wire logic               spi_miso_oe_o,
  input wire logic               analog_sel_i,
  input wire logic               sample_valid_i,
  input wire logic signed [15:0] rate_x_i,
  input wire logic signed [15:0] rate_y_i,
  input wire logic               x_axis_density_out_o,
  input wire logic               y_axis_density_out_o,
  input wire logic               pump_output_o,
  input wire logic               measuring_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [31:0] run_q;

  // cycles spent out of standby; a stuck settle timer shows up here
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q <= 32'h0;
    end else if (pump_output_o) begin
      run_q <= run_q + 32'h1;
    end else begin
      run_q <= 32'h0;
    end
  end

  logic       xd_prev_q;
  logic [3:0] xd_age_q;

  // age of the x density bit, saturating; looking back avoids firing when evaluation mode ends
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xd_prev_q <= 1'b0;
      xd_age_q  <= 4'hF;
    end else begin
      xd_prev_q <= x_axis_density_out_o;
      if (x_axis_density_out_o != xd_prev_q)
        xd_age_q <= 4'h0;
      else if (xd_age_q != 4'hF)
        xd_age_q <= xd_age_q + 4'h1;
    end
  end

  // mode pin held long enough to pass its synchroniser
  sequence s_eval_held;
    analog_sel_i [*5];
  endsequence
  sequence s_norm_held;
    !analog_sel_i [*5];
  endsequence

  a_meas_needs_run: assert property (measuring_o |-> pump_output_o)
    else $error("measuring while in standby");
  a_settle_min: assert property ($rose(measuring_o) |-> run_q + 3 >= START_CYCLES)
    else $error("measurement reached before settle time");
  a_settle_bound: assert property (pump_output_o && run_q == START_CYCLES + 4 |-> measuring_o)
    else $error("settle time overrun");
  a_stop_clears: assert property ($fell(pump_output_o) |-> !measuring_o)
    else $error("measurement outlived standby");
  a_wake_settles: assert property ($rose(pump_output_o) |-> !measuring_o)
    else $error("skipped settling on wake");
  a_eval_active: assert property (s_eval_held |-> pump_output_o)
    else $error("standby entered in evaluation mode");
  a_density_idle: assert property (s_norm_held |-> !x_axis_density_out_o && !y_axis_density_out_o)
    else $error("density stream outside evaluation mode");
  a_density_pace: assert property (analog_sel_i && $past(analog_sel_i, 8) &&
    $changed(x_axis_density_out_o) |-> xd_age_q >= 4'h8)
    else $error("density bit changed too soon");
  a_cs_idle_oe: assert property (spi_cs_n_i [*3] |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  a_cs_sel_oe: assert property (!spi_cs_n_i [*3] |-> spi_miso_oe_o)
    else $error("miso not driven while selected");
endmodule

bind gmb_top gmb_top_monitor #(.START_CYCLES(START_CYCLES)) u_mon (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i),
  .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .analog_sel_i(analog_sel_i), .sample_valid_i(sample_valid_i), .rate_x_i(rate_x_i),
  .rate_y_i(rate_y_i), .x_axis_density_out_o(x_axis_density_out_o),
  .y_axis_density_out_o(y_axis_density_out_o), .pump_output_o(pump_output_o), .measuring_o(measuring_o));
`default_nettype wire

// *** sim/gmb_spi_host.sv ***
// gmb_spi_host: behavioural serial master in clock mode 3 for the register port.
// assumes the device samples on sclk rise and changes miso after each fall.
`timescale 1ns/10ps
`default_nettype none
module gmb_spi_host (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  int half = 4;  // clk cycles per sclk phase; 4 gives the 800 ns link period

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // command byte then nb data bytes; sclk stands high outside frames
  task automatic frame(input logic [7:0] cmd, input int nb, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    wt(1);
    cs_n_o = 1'b0;
    wt(half);
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      sclk_o = 1'b0;
      mosi_o = sh[23 - i];  // msb first, changed on the falling edge
      wt(half);
      sclk_o = 1'b1;
      wt(half);
      if (i >= 8) rd = {rd[14:0], miso_i};  // late in the high phase: miso long settled
    end
    wt(half);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;  // released line has no pull, so show a fresh level
    wt(2 * half);
  endtask
endmodule
`default_nettype wire

// *** sim/gmb_top_test.sv ***
// gmb_top_test: self-checking bench for mode control, filter registers and density streams.
// assumes gmb_spi_host as serial master and a short settle count.
`timescale 1ns/10ps
`default_nettype none
module gmb_top_test;
  localparam int unsigned SETTLE = 50;
  logic clk, arst_n, cs_n, sclk, mosi, miso, miso_oe, asel, sv, xd, yd, pump, meas;
  logic signed [15:0] rx, ry;
  logic [15:0]        rd;
  int n_errors = 0;
  int compares = 0;
  int seed     = 7120;
  int pwr_m, flt_m, xo, yo, v, em, ym;

  gmb_top #(.START_CYCLES(SETTLE)) uut (
    .clk_i(clk), .arst_n_i(arst_n), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .analog_sel_i(asel), .sample_valid_i(sv),
    .rate_x_i(rx), .rate_y_i(ry), .x_axis_density_out_o(xd), .y_axis_density_out_o(yd),
    .pump_output_o(pump), .measuring_o(meas));
  gmb_spi_host host (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // single-register accesses keep the model in step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({1'b0, a}, 1, {d, 8'h00}, rd);
  endtask
  task automatic rdc(input string what, input logic [6:0] a, input int exp);
    host.frame({1'b1, a}, 1, 16'h0000, rd);
    chk(what, {8'h00, rd[7:0]}, exp[15:0]);
  endtask
  task automatic samp(input int n);
    repeat (n) begin
      @(negedge clk) sv = 1'b1;
      @(negedge clk) sv = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  // integer model of one axis, low-pass code 0: offset estimate in 16.16
  task automatic hpf_run(input int n, input int sh);
    repeat (n) begin
      samp(1);
      ym = xo - (em >>> 16);
      em += ((xo <<< 16) - em) >>> sh;
    end
  endtask
  task automatic wait_pump(input logic lvl);
    for (int i = 0; i < 200 && pump !== lvl; i++) @(negedge clk);
    chk("pump", {15'h0, pump}, {15'h0, lvl});
  endtask
  task automatic note(input string t);
    $display("test %s done", t);
  endtask

  // watchdog sized at several times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0; asel = 1'b0; sv = 1'b0; rx = 16'h0000; ry = 16'h0000;
    pwr_m = 0; flt_m = 0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("pump", {15'h0, pump}, 16'h0000);
    rdc("power", gmb_pkg::ADDR_POWER_CTRL, pwr_m);
    rdc("filter", gmb_pkg::ADDR_FILTER, flt_m);
    rdc("unmapped", 7'h30, 0);
    rx = 16'h1234;
    samp(4);
    rdc("x lo standby", gmb_pkg::ADDR_RATE_X_LO, 0);
    note("reset");
    host.frame({1'b0, gmb_pkg::ADDR_POWER_CTRL}, 2, 16'h0055, rd);
    rdc("filter burst", gmb_pkg::ADDR_FILTER, flt_m);
    for (int h = 0; h <= 10; h++) begin
      v = (h << 4) | ($random(seed) & 15);
      wr(gmb_pkg::ADDR_FILTER, v[7:0]);
      flt_m = v & 8'hF7;
      rdc("filter code", gmb_pkg::ADDR_FILTER, flt_m);
    end
    note("codes");
    wr(gmb_pkg::ADDR_FILTER, 8'h00);
    wr(gmb_pkg::ADDR_POWER_CTRL, 8'h02);
    wait_pump(1'b1);
    for (int i = 0; i < SETTLE + 100 && meas !== 1'b1; i++) @(negedge clk);
    chk("measuring", {15'h0, meas}, 16'h0001);
    v = $random(seed);
    rx = v[15:0];
    samp(8);
    host.frame({1'b1, gmb_pkg::ADDR_RATE_X_LO}, 2, 16'h0000, rd);
    chk("x rate", rd, {v[7:0], v[15:8]});
    host.frame({1'b0, gmb_pkg::ADDR_POWER_CTRL}, 2, 16'h0221, rd);
    rdc("filter burst", gmb_pkg::ADDR_FILTER, 8'h21);
    wr(gmb_pkg::ADDR_FILTER, 8'hA0);
    xo = v >>> 20;  // small signed offset keeps the 16.16 sums inside an int
    rx = xo[15:0];
    em = 0;
    hpf_run(24, gmb_pkg::HPF_TOP_SHIFT);
    wr(gmb_pkg::ADDR_FILTER, 8'h10);
    hpf_run(4, gmb_pkg::HPF_SLOW_SHIFT);
    host.frame({1'b1, gmb_pkg::ADDR_RATE_X_LO}, 2, 16'h0000, rd);
    chk("x offset", rd, {ym[7:0], ym[15:8]});
    wr(gmb_pkg::ADDR_POWER_CTRL, 8'h00);
    wait_pump(1'b0);
    note("measure");
    asel = 1'b1;
    rx = 16'h7000;
    ry = 16'h9000;
    wait_pump(1'b1);
    wr(gmb_pkg::ADDR_FILTER, 8'hA7);
    samp(8);
    host.frame({1'b1, gmb_pkg::ADDR_RATE_X_LO}, 2, 16'h0000, rd);
    chk("x eval", rd, 16'h0070);
    wr(gmb_pkg::ADDR_POWER_CTRL, 8'h00);
    chk("pump eval", {15'h0, pump}, 16'h0001);
    xo = 0;
    yo = 0;
    repeat (69 * 40) begin
      @(negedge clk);
      xo += xd;
      yo += yd;
    end
    chk("density order", {15'h0, xo > yo + 1000}, 16'h0001);
    asel = 1'b0;
    wait_pump(1'b0);
    note("evaluation");
    end_of_test();
  end
endmodule
`default_nettype wire
